//--- acdr_clk_sel.sv
`timescale 1ns/1ps
`include "acdr_map.svh"

module acdr_clk_sel
    import acdr_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Routing bundle
    acdr_route_if.clk_mp route_io
);

    acdr_clk_state_t s_reg;
    acdr_clk_state_t s_next;

    function automatic logic pick_clk(input logic [`ACDR_NUM_CLK_SRC-1:0] src,
                                      input acdr_clk_code_t code);
        return src[code];
    endfunction : pick_clk

    always_comb begin
        s_next = s_reg;
        for (int d = 0; d < `ACDR_NUM_CLK_DST; d++) begin
            s_next.clk_out[d] = pick_clk(route_io.clk_src, route_io.clk_code[d]);
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign route_io.clk_out = s_reg.clk_out;

    genvar g;
    generate
        for (g = 0; g < `ACDR_NUM_CLK_DST; g++) begin : g_chk
            clk_tie_low_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
                route_io.clk_code[g] == `ACDR_CLK_LOW |=> route_io.clk_out[g] == 1'b0)
                else $error("clock route code low did not give zero");
            clk_tie_high_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
                route_io.clk_code[g] == `ACDR_CLK_HIGH |=> route_io.clk_out[g] == 1'b1)
                else $error("clock route code high did not give one");
            clk_gen_b_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
                route_io.clk_code[g] == `ACDR_CLK_GEN_B
                |=> route_io.clk_out[g] == $past(route_io.clk_src[29]))
                else $error("clock route did not follow generator B");
            clk_last_pin_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
                route_io.clk_code[g] == 5'h13
                |=> route_io.clk_out[g] == $past(route_io.clk_src[19]))
                else $error("clock route did not follow pin buffer 20");
        end
    endgenerate

endmodule : acdr_clk_sel

//--- acdr_dat_sel.sv
`timescale 1ns/1ps
`include "acdr_map.svh"

module acdr_dat_sel
    import acdr_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Routing bundle
    acdr_route_if.dat_mp route_io
);

    acdr_dat_state_t s_reg;
    acdr_dat_state_t s_next;

    // Reserved codes land on the zero padding and give a low level
    function automatic logic pick_dat(input logic [`ACDR_NUM_DAT_SRC-1:0] src,
                                      input acdr_dat_code_t code);
        logic [63:0] full;
        full = 64'(src);
        return full[code];
    endfunction : pick_dat

    always_comb begin
        s_next = s_reg;
        for (int d = 0; d < `ACDR_NUM_DAT_DST; d++) begin
            s_next.dat_out[d] = pick_dat(route_io.dat_src, route_io.dat_code[d]);
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign route_io.dat_out = s_reg.dat_out;

    genvar g;
    generate
        for (g = 0; g < `ACDR_NUM_DAT_DST; g++) begin : g_chk
            dat_spdif_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
                route_io.dat_code[g] == `ACDR_DAT_SPDIF
                |=> route_io.dat_out[g] == $past(route_io.dat_src[40]))
                else $error("data route did not follow receiver data");
            dat_tie_low_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
                route_io.dat_code[g] inside {`ACDR_DAT_LOW_A, `ACDR_DAT_LOW_B}
                |=> route_io.dat_out[g] == 1'b0)
                else $error("data route low code did not give zero");
            dat_conv_in_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
                route_io.dat_code[g] == `ACDR_DAT_CONV_IN_FIRST
                |=> route_io.dat_out[g] == $past(route_io.dat_src[36]))
                else $error("data route did not follow converter 0 input side");
        end
    endgenerate

endmodule : acdr_dat_sel

//--- acdr_map.svh
`ifndef ACDR_MAP_SVH
`define ACDR_MAP_SVH

// Register byte offsets
`define ACDR_CLK_ROUTE0_OFS 8'h00
`define ACDR_CLK_ROUTE1_OFS 8'h04
`define ACDR_CLK_ROUTE2_OFS 8'h08
`define ACDR_CLK_ROUTE3_OFS 8'h0c
`define ACDR_CLK_ROUTE4_OFS 8'h10
`define ACDR_DAT_ROUTE0_OFS 8'h14
`define ACDR_DAT_ROUTE1_OFS 8'h18
`define ACDR_DAT_ROUTE2_OFS 8'h1c
`define ACDR_DAT_ROUTE3_OFS 8'h20
`define ACDR_CLK_STATUS_OFS 8'h24
`define ACDR_DAT_STATUS_OFS 8'h28

// Register indices
`define ACDR_IDX_CLK0 4'h0
`define ACDR_IDX_CLK1 4'h1
`define ACDR_IDX_CLK2 4'h2
`define ACDR_IDX_CLK3 4'h3
`define ACDR_IDX_CLK4 4'h4
`define ACDR_IDX_DAT0 4'h5
`define ACDR_IDX_CLK_STAT 4'h9
`define ACDR_IDX_DAT_STAT 4'ha
`define ACDR_IDX_NONE 4'hf
`define ACDR_NUM_CFG 9

// Writable bits and reset value
`define ACDR_MASK_SIX_FIELDS 32'h3fff_ffff
`define ACDR_MASK_FOUR_FIELDS 32'h000f_ffff
`define ACDR_MASK_TWO_FIELDS 32'h0000_03ff
`define ACDR_CFG_RESET 32'h0000_0000

// Field widths and counts
`define ACDR_CLK_SEL_W 5
`define ACDR_DAT_SEL_W 6
`define ACDR_CLK_PER_REG 6
`define ACDR_DAT_PER_REG 5
`define ACDR_NUM_CLK_SRC 32
`define ACDR_NUM_DAT_SRC 44
`define ACDR_NUM_CLK_DST 18
`define ACDR_NUM_DAT_DST 20

// Clock source codes
`define ACDR_CLK_PIN_FIRST 5'h00
`define ACDR_CLK_SERIAL_FIRST 5'h14
`define ACDR_CLK_SPDIF 5'h1a
`define ACDR_CLK_SPDIF_TDM 5'h1b
`define ACDR_CLK_GEN_A 5'h1c
`define ACDR_CLK_GEN_B 5'h1d
`define ACDR_CLK_LOW 5'h1e
`define ACDR_CLK_HIGH 5'h1f

// Data source codes
`define ACDR_DAT_PIN_FIRST 6'h00
`define ACDR_DAT_SERIAL_FIRST 6'h14
`define ACDR_DAT_CONV_OUT_FIRST 6'h20
`define ACDR_DAT_CONV_IN_FIRST 6'h24
`define ACDR_DAT_SPDIF 6'h28
`define ACDR_DAT_LOW_A 6'h29
`define ACDR_DAT_LOW_B 6'h2a
`define ACDR_DAT_HIGH 6'h2b
`define ACDR_DAT_RSVD_FIRST 6'h2c

// Clock destinations of the generator external inputs and the generator B tie field
`define ACDR_DST_GEN_A_EXT 14
`define ACDR_DST_GEN_B_EXT 15
`define ACDR_EXTB_TIE_LSB 5
`define ACDR_EXTB_TIE_CODE 5'h1d

// Bus answers
`define ACDR_RESP_OKAY 2'b00
`define ACDR_RESP_SLVERR 2'b10

`endif

//--- acdr_periph_model.sv
`timescale 1ns/1ps

module acdr_periph_model (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Junctions of pin buffers and peripherals
    output logic [50:0] junction_o
);
    // Scrambled so neighbouring junctions do not move in lockstep
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            junction_o <= 51'h5_a3c9_6e1b_d247;
        end else begin
            junction_o <= junction_o ^ {junction_o[37:0], 13'h0} ^ {7'h0, junction_o[50:7]};
        end
    end
endmodule : acdr_periph_model

//--- acdr_pkg.sv
`include "acdr_map.svh"

package acdr_pkg;

    typedef logic [`ACDR_CLK_SEL_W-1:0] acdr_clk_code_t;
    typedef logic [`ACDR_DAT_SEL_W-1:0] acdr_dat_code_t;

    typedef struct packed {
        logic [`ACDR_NUM_CFG-1:0][31:0] cfg;
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } acdr_top_state_t;

    typedef struct packed {
        logic [`ACDR_NUM_CLK_DST-1:0] clk_out;
    } acdr_clk_state_t;

    typedef struct packed {
        logic [`ACDR_NUM_DAT_DST-1:0] dat_out;
    } acdr_dat_state_t;

endpackage : acdr_pkg

//--- acdr_route_if.sv
`timescale 1ns/1ps
`include "acdr_map.svh"

interface acdr_route_if;
    logic [`ACDR_NUM_CLK_SRC-1:0] clk_src;
    logic [`ACDR_NUM_DAT_SRC-1:0] dat_src;
    logic [`ACDR_NUM_CLK_DST-1:0][`ACDR_CLK_SEL_W-1:0] clk_code;
    logic [`ACDR_NUM_DAT_DST-1:0][`ACDR_DAT_SEL_W-1:0] dat_code;
    logic [`ACDR_NUM_CLK_DST-1:0] clk_out;
    logic [`ACDR_NUM_DAT_DST-1:0] dat_out;

    modport top_mp(output clk_src, dat_src, clk_code, dat_code, input clk_out, dat_out);
    modport clk_mp(input clk_src, clk_code, output clk_out);
    modport dat_mp(input dat_src, dat_code, output dat_out);
endinterface : acdr_route_if

//--- acdr_top.sv
// Contract
// - Peripherals meet only through this matrix
// - Each clock input uses one 5-bit selection
// - Fourth clock register selects generator external inputs
// - Fifth register code 29 ties generator B low
// - Clock codes 0x0-0x13 pick pin buffers
// - Clock codes 0x14-0x19 pick serial port clocks
// - Clock codes 0x1A, 0x1B pick receiver clocks
// - Clock codes 0x1C, 0x1D pick generator clocks
// - Clock codes 0x1E, 0x1F give low, high
// - Each data input uses one 6-bit selection
// - Data codes 0x0-0x13 pick pin buffers
// - Data codes 0x14-0x1F pick port channels A/B
// - Data codes 0x20-0x23 pick converter output side
// - Data codes 0x24-0x27 pick converter input side
// - Data code 0x28 picks receiver data
// - Data codes 0x29-0x2A low, 0x2B high
//
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`include "acdr_map.svh"

module acdr_top
    import acdr_pkg::*;
(
    // Clock and reset
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    // AXI4-Lite write address and data
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    // AXI4-Lite write response
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // AXI4-Lite read
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Clock sources
    input wire logic [19:0] PIN_BUFFER_OUTPUT_I,
    input wire logic [5:0] SERIAL_PORT_CLOCK_I,
    input wire logic SPDIF_RX_CLOCK_OUT_I,
    input wire logic SPDIF_RX_TDM_CLOCK_OUT_I,
    input wire logic CLKGEN_A_CLOCK_OUT_I,
    input wire logic CLKGEN_B_CLOCK_OUT_I,
    // Data sources
    input wire logic [5:0] SERIAL_PORT_DATA_A_I,
    input wire logic [5:0] SERIAL_PORT_DATA_B_I,
    input wire logic [3:0] CONVERTER_OUTPUT_SIDE_DATA_I,
    input wire logic [3:0] CONVERTER_INPUT_SIDE_DATA_I,
    input wire logic SPDIF_RX_DATA_OUT_I,
    // Routed clocks
    output logic [5:0] SERIAL_PORT_CLOCK_O,
    output logic [3:0] CONVERTER_IN_CLOCK_O,
    output logic [3:0] CONVERTER_OUT_CLOCK_O,
    output logic CLKGEN_A_EXTERNAL_IN_O,
    output logic CLKGEN_B_EXTERNAL_IN_O,
    output logic [1:0] INPUT_DATA_PORT_CLOCK_O,
    // Routed data
    output logic [5:0] SERIAL_PORT_DATA_A_O,
    output logic [5:0] SERIAL_PORT_DATA_B_O,
    output logic [7:0] INPUT_DATA_PORT_DATA_O
);

    acdr_top_state_t s_reg;
    acdr_top_state_t s_next;
    acdr_route_if route_bus();
    logic [11:0] serial_ab;
    logic aw_take;
    logic w_take;
    logic wr_fire;
    logic [3:0] wr_idx;
    logic extb_tie;

    // Address decode shared by the write and read paths
    function automatic logic [3:0] reg_index(input logic [7:0] addr);
        if (addr == `ACDR_CLK_ROUTE0_OFS) begin
            return `ACDR_IDX_CLK0;
        end else if (addr == `ACDR_CLK_ROUTE1_OFS) begin
            return `ACDR_IDX_CLK1;
        end else if (addr == `ACDR_CLK_ROUTE2_OFS) begin
            return `ACDR_IDX_CLK2;
        end else if (addr == `ACDR_CLK_ROUTE3_OFS) begin
            return `ACDR_IDX_CLK3;
        end else if (addr == `ACDR_CLK_ROUTE4_OFS) begin
            return `ACDR_IDX_CLK4;
        end else if (addr == `ACDR_DAT_ROUTE0_OFS) begin
            return `ACDR_IDX_DAT0;
        end else if (addr == `ACDR_DAT_ROUTE1_OFS) begin
            return 4'h6;
        end else if (addr == `ACDR_DAT_ROUTE2_OFS) begin
            return 4'h7;
        end else if (addr == `ACDR_DAT_ROUTE3_OFS) begin
            return 4'h8;
        end else if (addr == `ACDR_CLK_STATUS_OFS) begin
            return `ACDR_IDX_CLK_STAT;
        end else if (addr == `ACDR_DAT_STATUS_OFS) begin
            return `ACDR_IDX_DAT_STAT;
        end else begin
            return `ACDR_IDX_NONE;
        end
    endfunction : reg_index

    // Bits that hold whole selection fields in each routing register
    function automatic logic [31:0] cfg_mask(input logic [3:0] idx);
        if (idx == `ACDR_IDX_CLK0) begin
            return `ACDR_MASK_SIX_FIELDS;
        end else if (idx == `ACDR_IDX_CLK1 || idx == `ACDR_IDX_CLK2) begin
            return `ACDR_MASK_FOUR_FIELDS;
        end else if (idx == `ACDR_IDX_CLK3 || idx == `ACDR_IDX_CLK4) begin
            return `ACDR_MASK_TWO_FIELDS;
        end else begin
            return `ACDR_MASK_SIX_FIELDS;
        end
    endfunction : cfg_mask

    // Register and field of each clock destination
    function automatic int clk_reg_of(input int d);
        if (d < 6) begin
            return 0;
        end else if (d < 10) begin
            return 1;
        end else if (d < 14) begin
            return 2;
        end else if (d < 16) begin
            return 3;
        end else begin
            return 4;
        end
    endfunction : clk_reg_of

    function automatic int clk_fld_of(input int d);
        if (d < 6) begin
            return d;
        end else if (d < 10) begin
            return d - 6;
        end else if (d < 14) begin
            return d - 10;
        end else if (d < 16) begin
            return d - 14;
        end else begin
            return d - 16;
        end
    endfunction : clk_fld_of

    // Source vectors: bit position equals selection code
    genvar p;
    generate
        for (p = 0; p < 6; p++) begin : g_serial
            assign serial_ab[2*p] = SERIAL_PORT_DATA_A_I[p];
            assign serial_ab[2*p+1] = SERIAL_PORT_DATA_B_I[p];
        end
    endgenerate

    assign route_bus.clk_src = {1'b1, 1'b0,
                                CLKGEN_B_CLOCK_OUT_I, CLKGEN_A_CLOCK_OUT_I,
                                SPDIF_RX_TDM_CLOCK_OUT_I, SPDIF_RX_CLOCK_OUT_I,
                                SERIAL_PORT_CLOCK_I,
                                PIN_BUFFER_OUTPUT_I};
    assign route_bus.dat_src = {1'b1, 1'b0, 1'b0,
                                SPDIF_RX_DATA_OUT_I,
                                CONVERTER_INPUT_SIDE_DATA_I,
                                CONVERTER_OUTPUT_SIDE_DATA_I,
                                serial_ab,
                                PIN_BUFFER_OUTPUT_I};

    // Selection fields straight from the registers, no handshake
    genvar d;
    generate
        for (d = 0; d < `ACDR_NUM_CLK_DST; d++) begin : g_clk_code
            localparam int R = clk_reg_of(d);
            localparam int L = `ACDR_CLK_SEL_W * clk_fld_of(d);
            assign route_bus.clk_code[d] = s_reg.cfg[R][L +: `ACDR_CLK_SEL_W];
        end
        for (d = 0; d < `ACDR_NUM_DAT_DST; d++) begin : g_dat_code
            localparam int R = 5 + d / `ACDR_DAT_PER_REG;
            localparam int L = `ACDR_DAT_SEL_W * (d % `ACDR_DAT_PER_REG);
            assign route_bus.dat_code[d] = s_reg.cfg[R][L +: `ACDR_DAT_SEL_W];
        end
    endgenerate

    acdr_clk_sel u_clk_sel (
        .clock_i(CLOCK_I),
        .rst_n_i(RST_N_I),
        .route_io(route_bus.clk_mp)
    );

    acdr_dat_sel u_dat_sel (
        .clock_i(CLOCK_I),
        .rst_n_i(RST_N_I),
        .route_io(route_bus.dat_mp)
    );

    // Every peripheral input leaves through the matrix
    assign SERIAL_PORT_CLOCK_O = route_bus.clk_out[5:0];
    assign CONVERTER_IN_CLOCK_O = route_bus.clk_out[9:6];
    assign CONVERTER_OUT_CLOCK_O = route_bus.clk_out[13:10];
    assign CLKGEN_A_EXTERNAL_IN_O = route_bus.clk_out[`ACDR_DST_GEN_A_EXT];
    assign extb_tie = s_reg.cfg[`ACDR_IDX_CLK4][`ACDR_EXTB_TIE_LSB +: `ACDR_CLK_SEL_W]
                      == `ACDR_EXTB_TIE_CODE;
    assign CLKGEN_B_EXTERNAL_IN_O = route_bus.clk_out[`ACDR_DST_GEN_B_EXT] & ~extb_tie;
    assign INPUT_DATA_PORT_CLOCK_O = route_bus.clk_out[17:16];
    assign SERIAL_PORT_DATA_A_O = {route_bus.dat_out[10], route_bus.dat_out[8],
                                   route_bus.dat_out[6], route_bus.dat_out[4],
                                   route_bus.dat_out[2], route_bus.dat_out[0]};
    assign SERIAL_PORT_DATA_B_O = {route_bus.dat_out[11], route_bus.dat_out[9],
                                   route_bus.dat_out[7], route_bus.dat_out[5],
                                   route_bus.dat_out[3], route_bus.dat_out[1]};
    assign INPUT_DATA_PORT_DATA_O = route_bus.dat_out[19:12];

    // Bus handshakes
    assign S_AXI_AWREADY = !s_reg.aw_held && !s_reg.bvalid;
    assign S_AXI_WREADY = !s_reg.w_held && !s_reg.bvalid;
    assign S_AXI_ARREADY = !s_reg.rvalid;
    assign aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
    assign w_take = S_AXI_WVALID && S_AXI_WREADY;
    assign wr_fire = (s_reg.aw_held || aw_take) && (s_reg.w_held || w_take);
    assign wr_idx = reg_index(aw_take ? S_AXI_AWADDR : s_reg.aw_addr);

    always_comb begin
        logic [3:0] rd_idx;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [31:0] merged;
        rd_idx = reg_index(S_AXI_ARADDR);
        wdata = w_take ? S_AXI_WDATA : s_reg.w_data;
        wstrb = w_take ? S_AXI_WSTRB : s_reg.w_strb;
        merged = '0;
        s_next = s_reg;
        if (s_reg.bvalid && S_AXI_BREADY) begin
            s_next.bvalid = 1'b0;
        end
        if (s_reg.rvalid && S_AXI_RREADY) begin
            s_next.rvalid = 1'b0;
        end
        if (aw_take) begin
            s_next.aw_held = 1'b1;
            s_next.aw_addr = S_AXI_AWADDR;
        end
        if (w_take) begin
            s_next.w_held = 1'b1;
            s_next.w_data = S_AXI_WDATA;
            s_next.w_strb = S_AXI_WSTRB;
        end
        if (wr_fire) begin
            s_next.aw_held = 1'b0;
            s_next.w_held = 1'b0;
            s_next.bvalid = 1'b1;
            if (wr_idx < 4'(`ACDR_NUM_CFG)) begin
                merged = s_reg.cfg[wr_idx];
                for (int b = 0; b < 4; b++) begin
                    if (wstrb[b]) begin
                        merged[8*b +: 8] = wdata[8*b +: 8];
                    end
                end
                s_next.cfg[wr_idx] = merged & cfg_mask(wr_idx);
                s_next.bresp = `ACDR_RESP_OKAY;
            end else begin
                s_next.bresp = `ACDR_RESP_SLVERR;
            end
        end
        if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            s_next.rvalid = 1'b1;
            s_next.rresp = `ACDR_RESP_OKAY;
            if (rd_idx < 4'(`ACDR_NUM_CFG)) begin
                s_next.rdata = s_reg.cfg[rd_idx];
            end else if (rd_idx == `ACDR_IDX_CLK_STAT) begin
                s_next.rdata = 32'(route_bus.clk_out);
            end else if (rd_idx == `ACDR_IDX_DAT_STAT) begin
                s_next.rdata = 32'(route_bus.dat_out);
            end else begin
                s_next.rdata = 32'h0000_0000;
                s_next.rresp = `ACDR_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            s_reg <= '0;
            s_reg.cfg <= {`ACDR_NUM_CFG{`ACDR_CFG_RESET}};
        end else begin
            s_reg <= s_next;
        end
    end

    assign S_AXI_BVALID = s_reg.bvalid;
    assign S_AXI_BRESP = s_reg.bresp;
    assign S_AXI_RVALID = s_reg.rvalid;
    assign S_AXI_RDATA = s_reg.rdata;
    assign S_AXI_RRESP = s_reg.rresp;

    // A full write of the serial port 0 clock field
    sequence clk0_write_s;
        wr_fire && wr_idx == `ACDR_IDX_CLK0 && (w_take ? S_AXI_WSTRB[0] : s_reg.w_strb[0]);
    endsequence

    // Reset must be seen high too: the edge that releases it does not load the flops
    sequence clk0_pin1_s;
        RST_N_I && route_bus.clk_code[0] == `ACDR_CLK_PIN_FIRST;
    endsequence

    wr_to_route_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        clk0_write_s |=> route_bus.clk_code[0]
            == $past(w_take ? S_AXI_WDATA[4:0] : s_reg.w_data[4:0]))
        else $error("written clock selection did not reach the matrix");

    cfg_hold_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        !wr_fire |=> $stable(s_reg.cfg))
        else $error("routing registers changed without a write");

    pin1_route_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        clk0_pin1_s ##1 clk0_pin1_s |-> SERIAL_PORT_CLOCK_O[0] == $past(PIN_BUFFER_OUTPUT_I[0]))
        else $error("serial port 0 clock did not follow pin buffer 1");

    extb_tie_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        extb_tie |-> !CLKGEN_B_EXTERNAL_IN_O)
        else $error("generator B external input not tied low");

    gen_a_ext_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        s_reg.cfg[`ACDR_IDX_CLK3][4:0] == `ACDR_CLK_HIGH [*2] |-> CLKGEN_A_EXTERNAL_IN_O)
        else $error("generator A external input ignored its selection");

    wr_resp_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        wr_fire |=> S_AXI_BVALID && !S_AXI_AWREADY && !S_AXI_WREADY)
        else $error("write response missing one cycle after write");

    rd_resp_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
        else $error("read response missing one cycle after address");

    serial_b_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        route_bus.dat_code[1] == 6'h15
        |=> SERIAL_PORT_DATA_B_O[0] == $past(SERIAL_PORT_DATA_B_I[0]))
        else $error("port 0 channel B data not routed from code 0x15");

endmodule : acdr_top

//--- tb_audio_clock_data_route_mux.sv
`timescale 1ns/1ps

module tb_audio_clock_data_route_mux;
    logic CLOCK_I, RST_N_I, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
    logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
    logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR, INPUT_DATA_PORT_DATA_O;
    logic [31:0] S_AXI_WDATA, S_AXI_RDATA, csrc;
    logic [3:0] S_AXI_WSTRB, CONVERTER_OUTPUT_SIDE_DATA_I, CONVERTER_INPUT_SIDE_DATA_I;
    logic [3:0] CONVERTER_IN_CLOCK_O, CONVERTER_OUT_CLOCK_O;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP, INPUT_DATA_PORT_CLOCK_O;
    logic [19:0] PIN_BUFFER_OUTPUT_I, dout;
    logic [5:0] SERIAL_PORT_CLOCK_I, SERIAL_PORT_DATA_A_I, SERIAL_PORT_DATA_B_I;
    logic [5:0] SERIAL_PORT_CLOCK_O, SERIAL_PORT_DATA_A_O, SERIAL_PORT_DATA_B_O;
    logic SPDIF_RX_CLOCK_OUT_I, SPDIF_RX_TDM_CLOCK_OUT_I, CLKGEN_A_CLOCK_OUT_I;
    logic CLKGEN_B_CLOCK_OUT_I, SPDIF_RX_DATA_OUT_I;
    logic CLKGEN_A_EXTERNAL_IN_O, CLKGEN_B_EXTERNAL_IN_O;
    logic [50:0] jn;
    logic [43:0] dsrc;
    logic [17:0] cout;
    int n_errors = 0;
    int comparisons = 0;

    assign {SPDIF_RX_DATA_OUT_I, CONVERTER_INPUT_SIDE_DATA_I, CONVERTER_OUTPUT_SIDE_DATA_I,
        SERIAL_PORT_DATA_B_I, SERIAL_PORT_DATA_A_I, CLKGEN_B_CLOCK_OUT_I, CLKGEN_A_CLOCK_OUT_I,
        SPDIF_RX_TDM_CLOCK_OUT_I, SPDIF_RX_CLOCK_OUT_I, SERIAL_PORT_CLOCK_I,
        PIN_BUFFER_OUTPUT_I} = jn;
    assign csrc = {2'b10, jn[29:0]};
    assign cout = {INPUT_DATA_PORT_CLOCK_O, CLKGEN_B_EXTERNAL_IN_O, CLKGEN_A_EXTERNAL_IN_O,
        CONVERTER_OUT_CLOCK_O, CONVERTER_IN_CLOCK_O, SERIAL_PORT_CLOCK_O};
    always_comb begin
        dsrc = {3'b100, jn[50:42], 12'h0, jn[19:0]};
        dout = {INPUT_DATA_PORT_DATA_O, 12'h0};
        for (int p = 0; p < 6; p++) begin
            dsrc[20 + 2 * p] = jn[30 + p];
            dsrc[21 + 2 * p] = jn[36 + p];
            dout[2 * p] = SERIAL_PORT_DATA_A_O[p];
            dout[2 * p + 1] = SERIAL_PORT_DATA_B_O[p];
        end
    end

    acdr_top acdr_top_inst (.*);
    acdr_periph_model acdr_periph_model_inst (
        .clock_i(CLOCK_I),
        .rst_n_i(RST_N_I),
        .junction_o(jn)
    );

    initial begin
        CLOCK_I = 1'b0;
        forever #2 CLOCK_I = ~CLOCK_I;
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge CLOCK_I);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= d;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        repeat (40) begin
            @(posedge CLOCK_I);
            if (S_AXI_AWREADY && S_AXI_AWVALID) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WREADY && S_AXI_WVALID) S_AXI_WVALID <= 1'b0;
            if (S_AXI_BVALID) begin
                S_AXI_BREADY <= 1'b0;
                cmp(32'(S_AXI_BRESP), 32'(er));
                return;
            end
        end
        cmp(32'h0, 32'h1);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge CLOCK_I);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        repeat (40) begin
            @(posedge CLOCK_I);
            if (S_AXI_ARREADY && S_AXI_ARVALID) S_AXI_ARVALID <= 1'b0;
            if (S_AXI_RVALID) begin
                S_AXI_RREADY <= 1'b0;
                cmp(S_AXI_RDATA, ed);
                cmp(32'(S_AXI_RRESP), 32'(er));
                return;
            end
        end
        cmp(32'h0, 32'h1);
    endtask : rd

    // Routed value must equal the chosen source as it stood before the edge
    task automatic route_chk(input bit dat, input int k, input int c);
        logic e;
        repeat (2) begin
            @(posedge CLOCK_I);
            e = dat ? dsrc[c] : csrc[c];
            #1;
            cmp(32'(dat ? dout[k] : cout[k]), 32'(e));
        end
    endtask : route_chk

    task automatic print_verdict();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict

    initial begin
        #300_000;
        n_errors++;
        print_verdict();
    end

    initial begin
        RST_N_I = 1'b0;
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h0;
        S_AXI_AWADDR = 8'h00;
        S_AXI_ARADDR = 8'h00;
        S_AXI_WDATA = 32'h0;
        S_AXI_WSTRB = 4'hf;
        repeat (2) @(posedge CLOCK_I);
        RST_N_I <= 1'b1;
        #1;
        cmp(32'({S_AXI_AWREADY, S_AXI_WREADY, S_AXI_ARREADY, S_AXI_BVALID, cout}),
            32'({3'h7, 19'h0}));
        route_chk(0, 17, 0);
        for (int k = 0; k < 18; k++) begin
            for (int c = 0; c < 32; c++) begin
                wr(k < 6 ? 8'h00 : k < 14 ? 8'(4 * ((k - 2) / 4)) : 8'(12 + 4 * (k / 16)),
                    32'(c) << (5 * (k < 6 ? k : k < 14 ? (k - 2) % 4 : k % 2)), 2'b00);
                route_chk(0, k, c);
            end
        end
        for (int d = 0; d < 20; d++) begin
            for (int c = 0; c < 44; c++) begin
                wr(8'(20 + 4 * (d / 5)), 32'(c) << (6 * (d % 5)), 2'b00);
                route_chk(1, d, c);
            end
        end
        wr(8'h0c, 32'h3e0, 2'b00);
        wr(8'h10, 32'h3a0, 2'b00);
        route_chk(0, 15, 30);
        route_chk(0, 17, 29);
        wr(8'h10, 32'h380, 2'b00);
        route_chk(0, 15, 31);
        rd(8'h00, 32'h3e00_0000, 2'b00);
        route_chk(0, 5, 31);
        // Only byte lane 0 lands: serial port 0 clock moves to pin buffer 20
        @(posedge CLOCK_I);
        S_AXI_WSTRB <= 4'h1;
        wr(8'h00, 32'hffff_ff13, 2'b00);
        S_AXI_WSTRB <= 4'hf;
        rd(8'h00, 32'h3e00_0013, 2'b00);
        route_chk(0, 0, 19);
        wr(8'h2c, 32'h1, 2'b10);
        rd(8'h2c, 32'h0, 2'b10);
        print_verdict();
    end
endmodule : tb_audio_clock_data_route_mux
